/* File: bus_cycle_seq.sv */
`default_nettype none
module bus_cycle_seq #(
  parameter int WAIT_W = 2
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // access request
  input wire logic req_i,
  input wire logic [2:0] area_i,
  input wire logic ext_i,
  input wire logic three_i,
  input wire logic [1:0] wait_i,
  // cycle status
  output logic strobe_o,
  output logic [2:0] area_o,
  output logic wait_st_o,
  output logic busy_o,
  output logic done_o
);

  // the wait field and its down-counter are fixed at two bits
  if (WAIT_W != 2) begin : g_wait_w_check
    $error("bus_cycle_seq: WAIT_W must be 2");
  end

  ext_wait_pkg::seq_s st;
  ext_wait_pkg::seq_s nxt_st;

  always_comb begin
    nxt_st = st;
    nxt_st.done = 1'b0;
    case (st.state)
      ext_wait_pkg::S_IDLE: begin
        if (req_i) begin
          nxt_st.state = ext_wait_pkg::S_T1;
          nxt_st.area = area_i;
          nxt_st.ext = ext_i;
          nxt_st.three = ext_i & three_i;
          nxt_st.wcnt = (ext_i & three_i) ? wait_i : 2'h0;
          nxt_st.strobe = ext_i;
          nxt_st.busy = 1'b1;
        end
      end
      ext_wait_pkg::S_T1: nxt_st.state = ext_wait_pkg::S_T2;
      ext_wait_pkg::S_T2: begin
        if (st.three) begin
          nxt_st.state = (st.wcnt != 2'h0) ? ext_wait_pkg::S_TW : ext_wait_pkg::S_T3;
          nxt_st.wait_st = (st.wcnt != 2'h0);
        end else begin
          // two-state external and on-chip cycles end here
          nxt_st.state = ext_wait_pkg::S_IDLE;
          nxt_st.done = 1'b1;
          nxt_st.strobe = 1'b0;
          nxt_st.busy = 1'b0;
        end
      end
      ext_wait_pkg::S_TW: begin
        // strobes and area held, the count moves; wait_st drops on the last wait
        nxt_st.wcnt = st.wcnt - 2'h1;
        if (st.wcnt == 2'h1) begin
          nxt_st.state = ext_wait_pkg::S_T3;
          nxt_st.wait_st = 1'b0;
        end
      end
      ext_wait_pkg::S_T3: begin
        nxt_st.state = ext_wait_pkg::S_IDLE;
        nxt_st.done = 1'b1;
        nxt_st.strobe = 1'b0;
        nxt_st.busy = 1'b0;
      end
      default: nxt_st = '0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= nxt_st;
    end
  end

  assign strobe_o = st.strobe;
  assign area_o = st.area;
  assign wait_st_o = st.wait_st;
  assign busy_o = st.busy;
  assign done_o = st.done;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  logic take;
  assign take = req_i && (st.state == ext_wait_pkg::S_IDLE);

  property p_three_wait3;
    take && ext_i && three_i && wait_i == 2'h3 |-> ##7 done_o;
  endproperty
  a_three_wait3: assert property (p_three_wait3) else $error("3 waits: wrong length");

  property p_three_wait0;
    take && ext_i && three_i && wait_i == 2'h0 |-> ##1 !done_o [*3] ##1 done_o;
  endproperty
  a_three_wait0: assert property (p_three_wait0) else $error("0 waits: wrong length");

  property p_two_state;
    take && ext_i && !three_i |-> ##3 done_o;
  endproperty
  a_two_state: assert property (p_two_state) else $error("two-state cycle length");

  property p_onchip;
    take && !ext_i |-> ##3 (done_o && !strobe_o);
  endproperty
  a_onchip: assert property (p_onchip) else $error("on-chip cycle length");

  property p_hold_in_wait;
    st.state == ext_wait_pkg::S_TW |=> $stable(area_o) && strobe_o;
  endproperty
  a_hold_in_wait: assert property (p_hold_in_wait) else $error("strobe/area moved in wait");

  c_wait3: cover property (take && ext_i && three_i && wait_i == 2'h3);
  c_two: cover property (take && ext_i && !three_i);
  c_onchip: cover property (take && !ext_i);

endmodule // bus_cycle_seq
`default_nettype wire

/* File: ext_wait_config.sv */
// Added by the designer: the placing of the registers and the strobed register port.
`include "ext_wait_consts.svh"
`default_nettype none
// Behaviour
// - Each area has a two-bit wait code giving zero to three program wait states.
// - Program waits apply only to areas selected for three-state access.
// - On-chip accesses take a fixed number of states whatever the wait codes hold.
// - Reset and hardware standby load all ones into both wait registers.
// - Software standby leaves both wait registers unchanged.
// - Upper wait register holds areas 7..4 in bit pairs 7:6 down to 1:0, msb high.
// - Lower wait register holds areas 3..0 in bit pairs 7:6 down to 1:0, msb high.
// - Both wait registers are 8 bits, fully read/write, reading back the last write.
// - An access-state bit of 0 gives two-state access, 1 gives three-state access.
module ext_wait_config (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // power modes
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  // access request
  input wire logic acc_req_i,
  input wire logic [2:0] acc_area_i,
  input wire logic acc_ext_i,
  // bus cycle status
  output logic ext_strobe_o,
  output logic [2:0] cyc_area_o,
  output logic wait_state_o,
  output logic busy_o,
  output logic done_o
);

  ext_wait_pkg::cfg_s st;
  ext_wait_pkg::cfg_s nxt_st;

  // ----------------------------------------
  // wait code selection
  // ----------------------------------------
  logic [15:0] wait_vec;
  logic [3:0] field_lsb;
  logic [1:0] area_wait;
  logic three_sel;
  logic seq_req;

  assign wait_vec = {st.upper, st.lower};
  assign field_lsb = {acc_area_i, 1'b0};
  assign area_wait = wait_vec[field_lsb +: `WAIT_FIELD_W];
  assign three_sel = st.ast[acc_area_i];
  // no new cycles while either standby is pending
  assign seq_req = acc_req_i & ~sw_standby_i & ~st.stby_sync;

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  always_comb begin
    nxt_st = st;
    nxt_st.stby_meta = hw_standby_i;
    nxt_st.stby_sync = st.stby_meta;
    nxt_st.rdata = `UNMAPPED_READ;
    if (rd_i) begin
      case (addr_i)
        `OFS_ACCESS_STATE_SELECT: nxt_st.rdata = st.ast;
        `OFS_WAIT_UPPER_AREAS: nxt_st.rdata = st.upper;
        `OFS_WAIT_LOWER_AREAS: nxt_st.rdata = st.lower;
        default: nxt_st.rdata = `UNMAPPED_READ;
      endcase
    end
    if (st.stby_sync) begin
      // hardware standby forces defaults, writes are lost meanwhile
      nxt_st.upper = `RST_WAIT_UPPER_AREAS;
      nxt_st.lower = `RST_WAIT_LOWER_AREAS;
      nxt_st.ast = `RST_ACCESS_STATE_SELECT;
    end else if (wr_i) begin
      // software standby has no term here: contents kept
      case (addr_i)
        `OFS_ACCESS_STATE_SELECT: nxt_st.ast = wdata_i;
        `OFS_WAIT_UPPER_AREAS: nxt_st.upper = wdata_i;
        `OFS_WAIT_LOWER_AREAS: nxt_st.lower = wdata_i;
        default: nxt_st.ast = st.ast;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st.upper <= `RST_WAIT_UPPER_AREAS;
      st.lower <= `RST_WAIT_LOWER_AREAS;
      st.ast <= `RST_ACCESS_STATE_SELECT;
      st.rdata <= `UNMAPPED_READ;
      st.stby_meta <= 1'b0;
      st.stby_sync <= 1'b0;
    end else begin
      st <= nxt_st;
    end
  end

  assign rdata_o = st.rdata;

  // ----------------------------------------
  // bus cycle sequencer
  // ----------------------------------------
  bus_cycle_seq #(
    .WAIT_W(`WAIT_FIELD_W)
  ) u_seq (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .req_i(seq_req),
    .area_i(acc_area_i),
    .ext_i(acc_ext_i),
    .three_i(three_sel),
    .wait_i(area_wait),
    .strobe_o(ext_strobe_o),
    .area_o(cyc_area_o),
    .wait_st_o(wait_state_o),
    .busy_o(busy_o),
    .done_o(done_o)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  property p_hw_standby_load;
    st.stby_sync |=> st.upper == `RST_WAIT_UPPER_AREAS && st.lower == `RST_WAIT_LOWER_AREAS;
  endproperty
  a_hw_standby_load: assert property (p_hw_standby_load) else $error("standby load failed");

  property p_standby_path;
    $rose(hw_standby_i) ##1 hw_standby_i |=> hw_standby_i |-> ##1 (st.upper == `RST_WAIT_UPPER_AREAS);
  endproperty
  a_standby_path: assert property (p_standby_path) else $error("standby slow");

  property p_write_upper;
    wr_i && addr_i == `OFS_WAIT_UPPER_AREAS && !st.stby_sync |=> st.upper == $past(wdata_i);
  endproperty
  a_write_upper: assert property (p_write_upper) else $error("upper write lost");

  property p_read_lower;
    rd_i && addr_i == `OFS_WAIT_LOWER_AREAS |=> rdata_o == $past(st.lower);
  endproperty
  a_read_lower: assert property (p_read_lower) else $error("lower readback wrong");

  property p_sw_keep;
    sw_standby_i && !wr_i && !st.stby_sync |=> $stable(st.upper) && $stable(st.lower);
  endproperty
  a_sw_keep: assert property (p_sw_keep) else $error("sw standby changed regs");

  property p_area7_field;
    acc_area_i == 3'h7 |-> area_wait == st.upper[7:6];
  endproperty
  a_area7_field: assert property (p_area7_field) else $error("area 7 field wrong");

  property p_area4_field;
    acc_area_i == 3'h4 |-> area_wait == st.upper[1:0];
  endproperty
  a_area4_field: assert property (p_area4_field) else $error("area 4 field wrong");

  property p_area0_field;
    acc_area_i == 3'h0 |-> area_wait == st.lower[1:0];
  endproperty
  a_area0_field: assert property (p_area0_field) else $error("area 0 field wrong");

  property p_area3_field;
    acc_area_i == 3'h3 |-> area_wait == st.lower[7:6];
  endproperty
  a_area3_field: assert property (p_area3_field) else $error("area 3 field wrong");

  property p_area6_field;
    acc_area_i == 3'h6 |-> area_wait == st.upper[5:4];
  endproperty
  a_area6_field: assert property (p_area6_field) else $error("area 6 field wrong");

  property p_area5_field;
    acc_area_i == 3'h5 |-> area_wait == st.upper[3:2];
  endproperty
  a_area5_field: assert property (p_area5_field) else $error("area 5 field wrong");

  property p_area2_field;
    acc_area_i == 3'h2 |-> area_wait == st.lower[5:4];
  endproperty
  a_area2_field: assert property (p_area2_field) else $error("area 2 field wrong");

  property p_area1_field;
    acc_area_i == 3'h1 |-> area_wait == st.lower[3:2];
  endproperty
  a_area1_field: assert property (p_area1_field) else $error("area 1 field wrong");

  property p_write_lower;
    wr_i && addr_i == `OFS_WAIT_LOWER_AREAS && !st.stby_sync |=> st.lower == $past(wdata_i);
  endproperty
  a_write_lower: assert property (p_write_lower) else $error("lower write lost");

  property p_read_upper;
    rd_i && addr_i == `OFS_WAIT_UPPER_AREAS |=> rdata_o == $past(st.upper);
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper readback wrong");

  property p_write_select;
    wr_i && addr_i == `OFS_ACCESS_STATE_SELECT && !st.stby_sync |=> st.ast == $past(wdata_i);
  endproperty
  a_write_select: assert property (p_write_select) else $error("select write lost");

  property p_read_idle;
    !rd_i |=> rdata_o == `UNMAPPED_READ;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");

  property p_two_state_nowait;
    seq_req && !busy_o && acc_ext_i && !three_sel |=> ##1 !wait_state_o ##1 done_o;
  endproperty
  a_two_state_nowait: assert property (p_two_state_nowait) else $error("two-state waited");

  c_standby: cover property (st.stby_sync);
  c_sw_standby_write: cover property (sw_standby_i && wr_i);

endmodule // ext_wait_config
`default_nettype wire

/* File: ext_wait_consts.svh */
`ifndef EXT_WAIT_CONSTS_SVH
`define EXT_WAIT_CONSTS_SVH

// register offsets on the plain register port
`define OFS_ACCESS_STATE_SELECT 8'h21
`define OFS_WAIT_UPPER_AREAS 8'h22
`define OFS_WAIT_LOWER_AREAS 8'h23

// reset values
`define RST_ACCESS_STATE_SELECT 8'hFF
`define RST_WAIT_UPPER_AREAS 8'hFF
`define RST_WAIT_LOWER_AREAS 8'hFF

// field layout: area n wait field sits at bits 2n+1:2n of {upper, lower}
`define WAIT_FIELD_W 2
`define AREA_IDX_W 3
`define UNMAPPED_READ 8'h00

`endif

/* File: ext_wait_pkg.sv */
`default_nettype none
package ext_wait_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_T1,
    S_T2,
    S_TW,
    S_T3
  } seq_state_e;

  typedef struct packed {
    seq_state_e state;
    logic [1:0] wcnt;
    logic three;
    logic ext;
    logic [2:0] area;
    logic strobe;
    logic wait_st;
    logic busy;
    logic done;
  } seq_s;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
    logic [7:0] ast;
    logic [7:0] rdata;
    logic stby_meta;
    logic stby_sync;
  } cfg_s;

endpackage
`default_nettype wire

/* File: test_ext_wait_config.sv */
`default_nettype none
module test_ext_wait_config;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // design hookup
  // ----------------------------------------
  logic mclk_i, nrst_i, wr_i, rd_i, hw_standby_i, sw_standby_i, acc_req_i, acc_ext_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [2:0] acc_area_i, cyc_area_o;
  logic ext_strobe_o, wait_state_o, busy_o, done_o;
  int fails;
  int tests_run;

  ext_wait_config dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .hw_standby_i(hw_standby_i),
    .sw_standby_i(sw_standby_i), .acc_req_i(acc_req_i), .acc_area_i(acc_area_i),
    .acc_ext_i(acc_ext_i), .ext_strobe_o(ext_strobe_o), .cyc_area_o(cyc_area_o),
    .wait_state_o(wait_state_o), .busy_o(busy_o), .done_o(done_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task automatic print_verdict;
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) begin
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
    end
    @(posedge mclk_i) wr_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk_i) begin
      rd_i <= 1'b1;
      addr_i <= a;
    end
    @(posedge mclk_i) rd_i <= 1'b0;
    #1 chk(what, rdata_o, exp);
  endtask

  // counts cycles from the taking edge to done, plus wait, strobe and busy cycles
  task automatic acc(input logic [2:0] a, input logic ext, input int lat_exp, input int w_exp);
    int lat;
    int w;
    int s;
    int b;
    int bad;
    lat = 0;
    w = 0;
    s = 0;
    b = 0;
    bad = 0;
    @(posedge mclk_i) begin
      acc_req_i <= 1'b1;
      acc_area_i <= a;
      acc_ext_i <= ext;
    end
    // first look lands in the cycle right after the taking edge
    @(posedge mclk_i) acc_req_i <= 1'b0;
    while (lat < 20) begin
      #1 lat++;
      if (ext_strobe_o === 1'b1) s++;
      if (busy_o === 1'b1) begin
        b++;
        if (cyc_area_o !== a) bad++;
      end
      if (wait_state_o === 1'b1) begin
        w++;
        if (ext_strobe_o !== 1'b1) bad++;
      end
      if (done_o === 1'b1) break;
      @(posedge mclk_i);
    end
    if (lat >= 20) begin
      fails++;
      print_verdict;
    end else begin
      chk("latency", 8'(lat), 8'(lat_exp));
      chk("wait cycles", 8'(w), 8'(w_exp));
      chk("strobe cycles", 8'(s), ext ? 8'(lat_exp - 1) : 8'h00);
      chk("busy cycles", 8'(b), 8'(lat_exp - 1));
      chk("held during wait", 8'(bad), 8'h00);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst_i = 1'b0;
    {wr_i, rd_i, hw_standby_i, sw_standby_i, acc_req_i, acc_ext_i} = '0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    acc_area_i = 3'h0;
    fails = 0;
    tests_run = 0;
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(8'h21, 8'hFF, "access state reset");
    rd(8'h22, 8'hFF, "upper reset");
    rd(8'h23, 8'hFF, "lower reset");
    rd(8'h40, 8'h00, "unmapped read");
    wr(8'h22, 8'h1B);
    wr(8'h23, 8'hE4);
    // unmapped write must leave both wait registers alone
    wr(8'h40, 8'h00);
    rd(8'h22, 8'h1B, "upper readback");
    rd(8'h23, 8'hE4, "lower readback");
    // codes: areas 0..3 get 0..3, areas 4..7 get 3..0
    for (int a = 0; a < 8; a++) begin
      acc(3'(a), 1'b1, 4 + (a < 4 ? a : 7 - a), (a < 4 ? a : 7 - a));
    end
    wr(8'h21, 8'h0F);
    rd(8'h21, 8'h0F, "access state readback");
    acc(3'h4, 1'b1, 3, 0);
    acc(3'h3, 1'b1, 7, 3);
    acc(3'h3, 1'b0, 3, 0);
    // software standby: contents kept, new cycles refused
    @(posedge mclk_i) sw_standby_i <= 1'b1;
    @(posedge mclk_i) acc_req_i <= 1'b1;
    @(posedge mclk_i) acc_req_i <= 1'b0;
    #1 chk("busy in standby", {7'h00, busy_o}, 8'h00);
    rd(8'h22, 8'h1B, "upper in sw standby");
    @(posedge mclk_i) sw_standby_i <= 1'b0;
    rd(8'h23, 8'hE4, "lower after sw standby");
    // hardware standby reloads all ones, writes during it are lost
    wr(8'h22, 8'h55);
    @(posedge mclk_i) hw_standby_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    wr(8'h23, 8'h00);
    @(posedge mclk_i) hw_standby_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd(8'h22, 8'hFF, "upper after hw standby");
    rd(8'h23, 8'hFF, "lower after hw standby");
    acc(3'h5, 1'b1, 7, 3);
    print_verdict;
  end
endmodule // test_ext_wait_config
`default_nettype wire
